// file: hdl/scmc_top.sv
// System clock controller: timing generator, machine cycle and operating-mode control
//
// Decided for this implementation: the plain strobed port and the address map.
`include "scmc_params.svh"
`timescale 1ns/10ps
`default_nettype none
module scmc_top
  import scmc_pkg::*;
#(
  parameter int PRE_STAGES = 2,
  parameter int DIV_STAGES = 21,
  parameter int LOW_STAGES = 6
)
(
  input  wire logic                     i_clk,
  input  wire logic                     i_reset_n,
  input  wire logic                     i_fc_tick,
  input  wire logic                     i_fs_tick,
  input  wire logic                     i_stop_active,
  input  wire logic                     i_stop_warmup,
  input  wire logic                     i_irq_request,
  input  wire logic                     i_interrupt_master_enable,
  input  wire logic                     i_timebase_int_enable,
  input  wire logic [3:0]               i_instr_len,
  input  wire logic [`SCMC_ADDR_W-1:0]  i_addr,
  input  wire logic [`SCMC_DATA_W-1:0]  i_wdata,
  input  wire logic                     i_write,
  input  wire logic                     i_read,
  output logic      [`SCMC_DATA_W-1:0]  o_rdata,
  output scmc_mode_t                    o_mode,
  output logic      [1:0]               o_state,
  output logic      [DIV_STAGES-1:0]    o_divider,
  output logic                          o_cpu_tick,
  output logic                          o_periph_tick,
  output logic                          o_tbt_tick,
  output logic                          o_instr_done,
  output logic                          o_high_osc_on,
  output logic                          o_low_osc_on,
  output logic                          o_low_pins_port,
  output logic                          o_wake_service,
  output logic                          o_wake_resume,
  output logic                          o_timebase_interrupt,
  output logic                          o_timebase_service
);

  localparam int UP_STAGES = DIV_STAGES - LOW_STAGES;

  function automatic logic is_slow(input scmc_mode_t m);
    is_slow = (m == SCMC_SLOW_DUAL) || (m == SCMC_SLOW_ONLY) || (m == SCMC_SLOW_DOZE);
  endfunction

  function automatic logic is_doze(input scmc_mode_t m);
    is_doze = (m == SCMC_LIGHT_DOZE) || (m == SCMC_DEEP_DOZE) ||
              (m == SCMC_FAST_DUAL_DOZE) || (m == SCMC_SLOW_DOZE);
  endfunction

  scmc_mode_t                mode;
  scmc_mode_t                next_mode;
  logic [PRE_STAGES-1:0]     prescaler;
  logic [DIV_STAGES-1:0]     divider;
  logic [1:0]                state;
  logic [3:0]                instr_cnt;
  logic [3:0]                instr_len_eff;
  logic                      high_osc_enable;
  logic                      low_osc_enable;
  logic                      system_clock_select;
  logic                      cpu_halt_req;
  logic                      timing_gen_halt;
  logic                      divider_stage7_source_select;
  logic [2:0]                timebase_clock_select;
  logic                      timebase_enable;
  logic                      timebase_latch;
  logic                      tbt_at_entry;
  logic                      wake_pend;
  logic                      stop_q;
  logic                      stop_from_fast;
  logic                      tbt_src_q;
  logic                      tbt_src;
  logic                      tbt_fall;
  logic                      first_on;
  logic                      pre_carry;
  logic                      low_carry;
  logic                      st7_fs;
  logic                      st7_tick;
  logic                      warm_fast;
  logic                      mtick;
  logic                      cycle_end;
  logic                      mode_change;
  logic                      stop_edge;
  logic                      wr_sys2;
  logic                      wr_tbc;
  logic                      wr_stat;

  assign wr_sys2 = i_write && (i_addr == `SCMC_OFF_SYS2);
  assign wr_tbc  = i_write && (i_addr == `SCMC_OFF_TBC);
  assign wr_stat = i_write && (i_addr == `SCMC_OFF_STAT);

  // Divider chain enables
  assign stop_edge = i_stop_active != stop_q;
  assign first_on  = !i_stop_active && (mode != SCMC_SLOW_ONLY) && (mode != SCMC_SLOW_DOZE);
  assign pre_carry = first_on && i_fc_tick && (&prescaler);
  assign low_carry = pre_carry && (&divider[LOW_STAGES-1:0]);
  assign warm_fast = i_stop_warmup && stop_from_fast;
  // Select bit honoured in every mode but the slow ones and warm-up after stop from fast run; software keeps it clear outside dual run
  assign st7_fs    = is_slow(mode) || (divider_stage7_source_select && !warm_fast);
  assign st7_tick  = st7_fs ? (i_fs_tick && !i_stop_active && o_low_osc_on) : low_carry;

  // Main clock follows the mode, and the mode only moves at a cycle boundary
  assign mtick     = !i_stop_active && (is_slow(mode) ? i_fs_tick : i_fc_tick);
  assign cycle_end = mtick && (state == `SCMC_LAST_STATE);

  assign tbt_src  = divider[`SCMC_TBT_TAP_BASE + timebase_clock_select];
  assign tbt_fall = tbt_src_q && !tbt_src;

  assign instr_len_eff = (i_instr_len < `SCMC_MIN_INSTR) ? `SCMC_MIN_INSTR :
                         (i_instr_len > `SCMC_MAX_INSTR) ? `SCMC_MAX_INSTR : i_instr_len;

  // Prescaler and divider
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      prescaler <= '0;
      divider   <= '0;
    end
    else if (stop_edge)
    begin
      prescaler <= '0;
      divider   <= '0;
    end
    else
    begin
      if (first_on && i_fc_tick)
        prescaler <= prescaler + 1'b1;
      if (pre_carry)
        divider[LOW_STAGES-1:0] <= divider[LOW_STAGES-1:0] + 1'b1;
      if (st7_tick)
        divider[DIV_STAGES-1:LOW_STAGES] <= divider[DIV_STAGES-1:LOW_STAGES] + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      stop_q         <= 1'b0;
      stop_from_fast <= 1'b0;
      tbt_src_q      <= 1'b0;
    end
    else
    begin
      stop_q    <= i_stop_active;
      tbt_src_q <= stop_edge ? 1'b0 : tbt_src;
      if (i_stop_active && !stop_q)
        stop_from_fast <= !is_slow(mode);
    end
  end

  // Machine-cycle states and instruction length
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state        <= 2'h0;
      instr_cnt    <= 4'h0;
      o_instr_done <= 1'b0;
    end
    else
    begin
      o_instr_done <= 1'b0;
      if (mtick)
        state <= state + 2'h1;
      if (cycle_end && !is_doze(mode))
      begin
        if (instr_cnt + 4'h1 >= instr_len_eff)
        begin
          instr_cnt    <= 4'h0;
          o_instr_done <= 1'b1;
        end
        else
          instr_cnt <= instr_cnt + 4'h1;
      end
    end
  end

  // Operating-mode transitions
  always_comb
  begin
    next_mode = mode;
    case (mode)
      SCMC_FAST_SINGLE:
        if (timing_gen_halt)
          next_mode = SCMC_DEEP_DOZE;
        else if (cpu_halt_req)
          next_mode = SCMC_LIGHT_DOZE;
        else if (low_osc_enable)
          next_mode = SCMC_FAST_DUAL;
      SCMC_LIGHT_DOZE:
        if (i_irq_request)
          next_mode = SCMC_FAST_SINGLE;
      SCMC_DEEP_DOZE:
        if (wake_pend)
          next_mode = SCMC_FAST_SINGLE;
      SCMC_FAST_DUAL:
        if (cpu_halt_req)
          next_mode = SCMC_FAST_DUAL_DOZE;
        else if (system_clock_select)
          next_mode = SCMC_SLOW_DUAL;
        else if (!low_osc_enable)
          next_mode = SCMC_FAST_SINGLE;
      SCMC_FAST_DUAL_DOZE:
        if (i_irq_request)
          next_mode = SCMC_FAST_DUAL;
      SCMC_SLOW_DUAL:
        if (cpu_halt_req)
          next_mode = SCMC_SLOW_DOZE;
        else if (!system_clock_select)
          next_mode = SCMC_FAST_DUAL;
        else if (!high_osc_enable)
          next_mode = SCMC_SLOW_ONLY;
      SCMC_SLOW_ONLY:
        if (cpu_halt_req)
          next_mode = SCMC_SLOW_DOZE;
        else if (high_osc_enable)
          next_mode = SCMC_SLOW_DUAL;
      SCMC_SLOW_DOZE:
        if (i_irq_request)
          next_mode = high_osc_enable ? SCMC_SLOW_DUAL : SCMC_SLOW_ONLY;
      default:
        next_mode = SCMC_FAST_SINGLE;
    endcase
  end

  assign mode_change = cycle_end && (next_mode != mode);

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      mode <= SCMC_FAST_SINGLE;
    else if (mode_change)
      mode <= next_mode;
  end

  // Deep doze wake-up and time-base latch
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wake_pend      <= 1'b0;
      tbt_at_entry   <= 1'b0;
      timebase_latch <= 1'b0;
    end
    else
    begin
      if (mode != SCMC_DEEP_DOZE)
        wake_pend <= 1'b0;
      else if (tbt_fall)
        wake_pend <= 1'b1;
      if (mode_change && next_mode == SCMC_DEEP_DOZE)
        tbt_at_entry <= timebase_enable;
      // Hardware set wins over a software clear in the same cycle
      if (mode_change && mode == SCMC_DEEP_DOZE && tbt_at_entry)
        timebase_latch <= 1'b1;
      else if (wr_stat && i_wdata[`SCMC_STAT_LATCH])
        timebase_latch <= 1'b0;
    end
  end

  // Software-visible control bits
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      high_osc_enable     <= 1'b1;
      low_osc_enable      <= 1'b0;
      system_clock_select <= 1'b0;
      cpu_halt_req        <= 1'b0;
      timing_gen_halt     <= 1'b0;
    end
    else if (wr_sys2)
    begin
      high_osc_enable     <= i_wdata[`SCMC_SYS2_HIEN];
      low_osc_enable      <= i_wdata[`SCMC_SYS2_LOEN];
      system_clock_select <= i_wdata[`SCMC_SYS2_SYSTEM_CLOCK_SELECT];
      cpu_halt_req        <= i_wdata[`SCMC_SYS2_HALT];
      timing_gen_halt     <= i_wdata[`SCMC_SYS2_TIMING_GEN_HALT];
    end
    else if (mode_change && is_doze(next_mode))
    begin
      // Halt requests are one-shot; consumed at doze entry
      cpu_halt_req    <= 1'b0;
      timing_gen_halt <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      divider_stage7_source_select <= 1'b0;
      timebase_clock_select        <= 3'h0;
      timebase_enable              <= 1'b0;
    end
    else if (wr_tbc)
    begin
      divider_stage7_source_select <= i_wdata[`SCMC_TBC_DV7];
      timebase_clock_select        <= i_wdata[`SCMC_TBC_SEL_MSB:`SCMC_TBC_SEL_LSB];
      timebase_enable              <= i_wdata[`SCMC_TBC_EN];
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_rdata <= '0;
    else if (i_read)
    begin
      o_rdata <= '0;
      case (i_addr)
        `SCMC_OFF_SYS2:
        begin
          o_rdata[`SCMC_SYS2_HIEN]   <= high_osc_enable;
          o_rdata[`SCMC_SYS2_LOEN]   <= low_osc_enable;
          o_rdata[`SCMC_SYS2_SYSTEM_CLOCK_SELECT]  <= system_clock_select;
          o_rdata[`SCMC_SYS2_HALT]   <= cpu_halt_req;
          o_rdata[`SCMC_SYS2_TIMING_GEN_HALT] <= timing_gen_halt;
        end
        `SCMC_OFF_TBC:
        begin
          o_rdata[`SCMC_TBC_DV7]                       <= divider_stage7_source_select;
          o_rdata[`SCMC_TBC_SEL_MSB:`SCMC_TBC_SEL_LSB] <= timebase_clock_select;
          o_rdata[`SCMC_TBC_EN]                        <= timebase_enable;
        end
        `SCMC_OFF_STAT:
        begin
          o_rdata[`SCMC_STAT_MODE_MSB:`SCMC_STAT_MODE_LSB] <= mode;
          o_rdata[`SCMC_STAT_ST_MSB:`SCMC_STAT_ST_LSB]     <= state;
          o_rdata[`SCMC_STAT_LATCH]                        <= timebase_latch;
          o_rdata[`SCMC_STAT_WARM]                         <= warm_fast;
        end
        default:
          o_rdata <= '0;
      endcase
    end
    else
      o_rdata <= '0;
  end

  // Registered outputs
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_cpu_tick         <= 1'b0;
      o_periph_tick      <= 1'b0;
      o_tbt_tick         <= 1'b0;
      o_high_osc_on      <= 1'b1;
      o_low_osc_on       <= 1'b0;
      o_low_pins_port    <= 1'b1;
      o_wake_service     <= 1'b0;
      o_wake_resume      <= 1'b0;
      o_timebase_service <= 1'b0;
    end
    else
    begin
      o_cpu_tick         <= mtick && !is_doze(mode);
      o_periph_tick      <= mtick && (mode != SCMC_DEEP_DOZE);
      o_tbt_tick         <= tbt_fall;
      o_high_osc_on      <= !i_stop_active && (high_osc_enable || !is_slow(mode));
      o_low_osc_on       <= !i_stop_active && (low_osc_enable || is_slow(mode));
      o_low_pins_port    <= (mode == SCMC_FAST_SINGLE) || (mode == SCMC_LIGHT_DOZE) ||
                            (mode == SCMC_DEEP_DOZE);
      o_wake_service     <= mode_change && is_doze(mode) && i_interrupt_master_enable;
      o_wake_resume      <= mode_change && is_doze(mode) && !i_interrupt_master_enable;
      o_timebase_service <= timebase_latch && i_interrupt_master_enable &&
                            i_timebase_int_enable && timebase_enable;
    end
  end

  assign o_mode               = mode;
  assign o_state              = state;
  assign o_divider            = divider;
  assign o_timebase_interrupt = timebase_latch;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_deep_exit;
    (mode == SCMC_DEEP_DOZE) && mode_change && tbt_at_entry ##1 (mode == SCMC_FAST_SINGLE);
  endsequence

  sequence s_stop_toggle;
    (i_stop_active != $past(i_stop_active)) ##1 1'b1;
  endsequence

  property p_state_advance;
    mtick |=> (state == $past(state) + 2'h1);
  endproperty
  a_state_advance: assert property (p_state_advance) else $error("state did not advance");

  property p_mode_boundary;
    (mode != $past(mode)) |-> $past(cycle_end);
  endproperty
  a_mode_boundary: assert property (p_mode_boundary) else $error("mode changed mid cycle");

  property p_div_clear;
    s_stop_toggle |-> (divider == '0);
  endproperty
  a_div_clear: assert property (p_div_clear) else $error("divider not cleared at stop edge");

  property p_slow_stage7;
    (is_slow(mode) && i_fs_tick && !i_stop_active && o_low_osc_on && !stop_edge)
      |=> (divider[DIV_STAGES-1:LOW_STAGES] == $past(divider[DIV_STAGES-1:LOW_STAGES]) + 1'b1);
  endproperty
  a_slow_stage7: assert property (p_slow_stage7) else $error("fs not feeding stage seven");

  property p_light_wake;
    (mode == SCMC_LIGHT_DOZE) && i_irq_request && cycle_end |=> (mode == SCMC_FAST_SINGLE);
  endproperty
  a_light_wake: assert property (p_light_wake) else $error("light doze not released");

  property p_deep_latch;
    s_deep_exit |-> timebase_latch;
  endproperty
  a_deep_latch: assert property (p_deep_latch) else $error("time-base latch not set");

  property p_deep_gate;
    (mode == SCMC_DEEP_DOZE) ##1 (mode == SCMC_DEEP_DOZE) |-> !o_periph_tick;
  endproperty
  a_deep_gate: assert property (p_deep_gate) else $error("peripheral clock in deep doze");

  property p_slow_first_stage;
    (mode == SCMC_SLOW_ONLY) && !stop_edge |=> (prescaler == $past(prescaler));
  endproperty
  a_slow_first_stage: assert property (p_slow_first_stage) else $error("first stage ran in slow-only");

  property p_instr_done;
    o_instr_done |-> (state == 2'h0) && $past(cycle_end);
  endproperty
  a_instr_done: assert property (p_instr_done) else $error("instruction ended off boundary");

endmodule
`default_nettype wire

// file: hdl/scmc_params.svh
// Constants of the system clock and operating-mode controller
// Overview of operation
// - Timing generator: 2-stage prescaler, 21-stage divider, main clock, machine-cycle counters.
// - Prescaler and divider clear to zero on reset and stop entry or release.
// - Stage-seven input chosen by mode, system clock select and stage-seven source select.
// - Slow run and slow doze feed fs to stage seven, ignoring the select bit.
// - Warm-up after stop from fast run feeds stage six into stage seven.
// - Machine cycle is four states S0..S3, one main clock each.
// - Instructions take one to ten machine cycles, synchronous to main clock.
// - Single-clock mode: only fc runs, low crystal pins are ports, cycle 4/fc.
// - Reset enters fast single run, everything clocked from fc.
// - CPU halt request enters light doze; peripherals keep running on fc.
// - Any interrupt request releases light doze back to fast single run.
// - On doze release, master enable set services interrupt, else resumes next instruction.
// - Timing generator halt enters deep doze; only time-base timer keeps clock.
// - Deep doze ends on falling edge of selected time-base source clock.
// - Deep doze ignores time-base enable; enabled at entry sets time-base latch after.
// - Time-base interrupt serviced only when master, individual and time-base enables set.
// - Dual mode runs both oscillators; main clock from fc fast, fs slow.
// - System clock select one gives slow dual run; zero returns fast dual run.
// - Clearing high oscillator enable in slow dual run gives slow-only run.
// - Slow-only run and slow doze stop divider stages one through six.
// - Fast dual doze enters like light doze, releases to fast dual run.
`ifndef SCMC_PARAMS_SVH
`define SCMC_PARAMS_SVH

`define SCMC_ADDR_W       4
`define SCMC_DATA_W       8
`define SCMC_OFF_SYS2     4'h0
`define SCMC_OFF_TBC      4'h4
`define SCMC_OFF_STAT     4'h8

`define SCMC_SYS2_HIEN    0
`define SCMC_SYS2_LOEN    1
`define SCMC_SYS2_SYSTEM_CLOCK_SELECT   2
`define SCMC_SYS2_HALT    3
`define SCMC_SYS2_TIMING_GEN_HALT  4

`define SCMC_TBC_DV7      0
`define SCMC_TBC_SEL_LSB  1
`define SCMC_TBC_SEL_MSB  3
`define SCMC_TBC_EN       4

`define SCMC_STAT_MODE_LSB 0
`define SCMC_STAT_MODE_MSB 2
`define SCMC_STAT_ST_LSB  3
`define SCMC_STAT_ST_MSB  4
`define SCMC_STAT_LATCH   5
`define SCMC_STAT_WARM    6

`define SCMC_LAST_STATE   2'h3
`define SCMC_MIN_INSTR    4'h1
`define SCMC_MAX_INSTR    4'ha
`define SCMC_TBT_TAP_BASE 13

`endif

// file: hdl/scmc_pkg.sv
// Types of the system clock and operating-mode controller
package scmc_pkg;

  typedef enum logic [2:0] {
    SCMC_FAST_SINGLE,
    SCMC_LIGHT_DOZE,
    SCMC_DEEP_DOZE,
    SCMC_FAST_DUAL,
    SCMC_FAST_DUAL_DOZE,
    SCMC_SLOW_DUAL,
    SCMC_SLOW_ONLY,
    SCMC_SLOW_DOZE
  } scmc_mode_t;

endpackage

// file: verification/scmc_osc_model.sv
// Oscillator model: fc and fs tick sources on the far side of the controller
`timescale 1ns/10ps
`default_nettype none
module scmc_osc_model
#(
  parameter int FC_DIV = 1,
  parameter int FS_DIV = 8
)
(
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_high_on,
  input  wire logic i_low_on,
  output logic      o_fc_tick,
  output logic      o_fs_tick
);
  int fc_cnt;
  int fs_cnt;

  // A disabled oscillator gives no ticks at all, so nothing downstream may keep counting
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      fc_cnt    <= 0;
      fs_cnt    <= 0;
      o_fc_tick <= 1'b0;
      o_fs_tick <= 1'b0;
    end
    else
    begin
      fc_cnt    <= (!i_high_on || fc_cnt == FC_DIV - 1) ? 0 : fc_cnt + 1;
      o_fc_tick <= i_high_on && fc_cnt == FC_DIV - 1;
      fs_cnt    <= (!i_low_on || fs_cnt == FS_DIV - 1) ? 0 : fs_cnt + 1;
      o_fs_tick <= i_low_on && fs_cnt == FS_DIV - 1;
    end
  end
endmodule
`default_nettype wire

// file: verification/test_system_clock_mode_controller.sv
// Self-checking testbench of the system clock and operating-mode controller
`timescale 1ns/10ps
`default_nettype none
module test_system_clock_mode_controller;
  import scmc_pkg::*;
  logic        i_clk, i_reset_n, fc_tick, fs_tick, irq, ime, i_write, i_read, rd_q;
  logic [3:0]  i_addr, i_instr_len;
  logic [7:0]  i_wdata, o_rdata;
  logic [20:0] o_divider;
  scmc_mode_t  o_mode;
  logic        hi_on, lo_on, pins_port, wake_srv, wake_res, tb_int, tb_srv;
  logic        cpu_tk, per_tk, tbt_tk, done_tk, stop, warm, tbie;
  logic [1:0]  st;
  logic [7:0]  exp_q[$];
  logic [7:0]  msk_q[$];
  int          err_total, samples_checked, seed, tbt_cnt;

  scmc_top u_scmc_top (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_fc_tick(fc_tick), .i_fs_tick(fs_tick),
    .i_stop_active(stop), .i_stop_warmup(warm), .i_irq_request(irq), .i_interrupt_master_enable(ime),
    .i_timebase_int_enable(tbie), .i_instr_len(i_instr_len), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .o_mode(o_mode), .o_state(st),
    .o_divider(o_divider), .o_cpu_tick(cpu_tk), .o_periph_tick(per_tk), .o_tbt_tick(tbt_tk),
    .o_instr_done(done_tk),
    .o_high_osc_on(hi_on), .o_low_osc_on(lo_on), .o_low_pins_port(pins_port),
    .o_wake_service(wake_srv), .o_wake_resume(wake_res), .o_timebase_interrupt(tb_int),
    .o_timebase_service(tb_srv));

  scmc_osc_model u_scmc_osc_model (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_high_on(hi_on),
    .i_low_on(lo_on), .o_fc_tick(fc_tick), .o_fs_tick(fs_tick));

  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_write <= 1'b1;
    @(posedge i_clk);
    i_write <= 1'b0;
  endtask

  // Expected read data is queued here and taken off by the read monitor
  task automatic reg_read(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge i_clk);
    exp_q.push_back(e);
    msk_q.push_back(m);
    i_addr <= a;
    i_read <= 1'b1;
    @(posedge i_clk);
    i_read <= 1'b0;
  endtask

  task automatic wait_mode(input scmc_mode_t m, input int lim);
    int n;
    n = 0;
    while (o_mode !== m && n < lim)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check("mode", 8'(m), 8'(o_mode));
  endtask

  task automatic next_cycle();
    @(posedge i_clk);
    #1;
  endtask

  always @(posedge i_clk)
  begin
    if (rd_q)
      check("rdata", exp_q.pop_front(), o_rdata & msk_q.pop_front());
    // An instruction may only end on a machine-cycle boundary
    if (done_tk === 1'b1)
      check("instr_state", 8'h00, 8'(st));
    if (tbt_tk === 1'b1)
      tbt_cnt++;
    rd_q <= i_read;
  end

  always @(posedge i_clk)
    i_instr_len <= 4'($random(seed));

  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // Deep doze waits for a slow divider tap, so the budget covers one full tap period
  initial
  begin
    repeat (90000) @(posedge i_clk);
    err_total++;
    test_done();
  end

  initial
  begin
    seed        = 77;
    i_reset_n   = 1'b0;
    irq         = 1'b0;
    ime         = 1'b0;
    i_write     = 1'b0;
    i_read      = 1'b0;
    rd_q        = 1'b0;
    i_addr      = 4'h0;
    i_wdata     = 8'h00;
    stop        = 1'b0;
    warm        = 1'b0;
    tbie        = 1'b1;
    repeat (5) @(posedge i_clk);
    i_reset_n <= 1'b1;
    next_cycle();
    check("mode", 8'(SCMC_FAST_SINGLE), 8'(o_mode));
    check("high_osc", 8'h01, 8'(hi_on));
    check("low_osc", 8'h00, 8'(lo_on));
    check("pins_port", 8'h01, 8'(pins_port));
    reg_read(4'h0, 8'h01, 8'hff);
    reg_read(4'hc, 8'h00, 8'hff);
    ime <= 1'b1;
    reg_write(4'h0, 8'h09);
    wait_mode(SCMC_LIGHT_DOZE, 50);
    next_cycle();
    check("cpu_tick", 8'h00, 8'(cpu_tk));
    check("periph_tick", 8'h01, 8'(per_tk));
    irq <= 1'b1;
    wait_mode(SCMC_FAST_SINGLE, 50);
    check("wake_service", 8'h01, 8'(wake_srv));
    irq <= 1'b0;
    reg_write(4'h0, 8'h03);
    wait_mode(SCMC_FAST_DUAL, 50);
    check("low_osc", 8'h01, 8'(lo_on));
    // Pin function is registered from the mode, so it trails the mode by a cycle
    next_cycle();
    check("pins_port", 8'h00, 8'(pins_port));
    reg_write(4'h0, 8'h07);
    wait_mode(SCMC_SLOW_DUAL, 200);
    reg_write(4'h0, 8'h06);
    wait_mode(SCMC_SLOW_ONLY, 200);
    check("high_osc", 8'h00, 8'(hi_on));
    reg_write(4'h0, 8'h07);
    wait_mode(SCMC_SLOW_DUAL, 200);
    reg_write(4'h0, 8'h03);
    wait_mode(SCMC_FAST_DUAL, 200);
    ime <= 1'b0;
    reg_write(4'h0, 8'h0b);
    wait_mode(SCMC_FAST_DUAL_DOZE, 50);
    irq <= 1'b1;
    wait_mode(SCMC_FAST_DUAL, 50);
    check("wake_resume", 8'h01, 8'(wake_res));
    irq <= 1'b0;
    reg_write(4'h0, 8'h01);
    wait_mode(SCMC_FAST_SINGLE, 50);
    reg_read(4'h8, 8'h00, 8'h07);
    ime <= 1'b1;
    reg_write(4'h4, 8'h10);
    reg_write(4'h0, 8'h11);
    wait_mode(SCMC_DEEP_DOZE, 50);
    next_cycle();
    check("periph_tick", 8'h00, 8'(per_tk));
    check("cpu_tick", 8'h00, 8'(cpu_tk));
    wait_mode(SCMC_FAST_SINGLE, 75000);
    repeat (3) next_cycle();
    check("tb_latch", 8'h01, 8'(tb_int));
    check("tb_service", 8'h01, 8'(tb_srv));
    @(posedge i_clk);
    tbie <= 1'b0;
    next_cycle();
    check("tb_service", 8'h00, 8'(tb_srv));
    reg_read(4'h8, 8'h20, 8'h20);
    reg_write(4'h8, 8'h20);
    repeat (2) next_cycle();
    check("tb_latch", 8'h00, 8'(tb_int));
    // Stop entered from fast run: divider cleared at both edges, warm-up flag raised
    @(posedge i_clk);
    stop <= 1'b1;
    next_cycle();
    check("div_stop_entry", 8'h01, 8'(o_divider == '0));
    repeat (3) next_cycle();
    check("div_in_stop", 8'h01, 8'(o_divider == '0));
    @(posedge i_clk);
    stop <= 1'b0;
    warm <= 1'b1;
    next_cycle();
    check("div_stop_exit", 8'h01, 8'(o_divider == '0));
    reg_read(4'h8, 8'h40, 8'h40);
    @(posedge i_clk);
    warm <= 1'b0;
    repeat (4) next_cycle();
    check("tbt_ticks", 8'h01, 8'(tbt_cnt));
    test_done();
  end
endmodule
`default_nettype wire
